// >>> dv/interrupt_request_mapper_bench.sv
// Bench: register, routing, priority and vector checks of the mapper
`default_nettype none
module interrupt_request_mapper_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_LVL = irm_pkg::ADDR_LVL0;
  localparam logic [7:0] A_ST = irm_pkg::ADDR_STAT0;
  localparam logic [7:0] A_MSK = irm_pkg::ADDR_MASK0;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] src = 16'h0000;
  logic [7:0] rdata, d;
  logic irq, vld;
  logic [4:0] num, t_num;
  logic [1:0] lvl;
  logic [15:0] vu, vl, t_up, t_lo;
  logic [7:0] t_cnt;
  logic [23:0] exp_st, st;
  int mismatches = 0;
  int cmp_count = 0;
  // Request that each source bit must reach: ext ch2..7, timers, others
  int req_of [16] = '{2, 3, 0, 1, 2, 3, 5, 6, 22, 14, 7, 8, 18, 19, 20, 23};

  always #4 clk = ~clk;

  irm_top dut_u (
    .CLK_SYS(clk), .RESETN(resetn), .CE(ce), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
    .EXT_REQ(src[5:0]), .TMR0_LO(src[6]), .TMR0_HI(src[7]),
    .TMR1_LO(src[8]), .TMR1_HI(src[9]), .UART_RX(src[10]),
    .UART_TX(src[11]), .ADC_DONE(src[12]), .TBT_TICK(src[13]),
    .WPRE_TICK(src[14]), .FLASH_DONE(src[15]), .IRQ(irq),
    .REQ_VALID(vld), .REQ_NUM(num), .REQ_LEVEL(lvl), .VEC_UPPER(vu),
    .VEC_LOWER(vl)
  );

  irm_cpu_model cpu_u (
    .clk(clk), .rst_n(resetn), .req_valid(vld), .req_num(num),
    .vec_upper(vu), .vec_lower(vl), .took_num(t_num),
    .took_upper(t_up), .took_lower(t_lo), .took_cnt(t_cnt)
  );

  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [23:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // One-cycle write strobe; the slave never stalls
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Write then read back with no gap between the two strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v,
                       output logic [7:0] q);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    q = rdata;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, e);
    rd(a, d);
    chk(n, 24'(d), 24'(e));
  endtask

  task automatic rd_stat(output logic [23:0] s);
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      rd(A_ST + 8'(i), b);
      s[i*8 +: 8] = b;
    end
  endtask

  task automatic wr3(input logic [7:0] base, input logic [7:0] v);
    for (int i = 0; i < 3; i++) wr(base + 8'(i), v);
  endtask

  // Source high for one edge, which sets status, then two edges for outputs and the CPU fetch
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    src <= v;
    @(posedge clk);
    src <= 16'h0000;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait2;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Hang guard: the whole run is far shorter than this
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("level_idle", 24'(lvl), 24'h3);
    chk("vec_idle", 24'(vu), 24'hfffa);
    // Reset values, then read/write of every level register
    for (int r = 0; r < 6; r++) rdchk("lvl_rst", A_LVL + 8'(r), 8'hff);
    for (int r = 0; r < 6; r++) begin
      wr_rd(A_LVL + 8'(r), 8'h1b + 8'(r), d);
      chk("lvl_rw", 24'(d), 24'(8'h1b + 8'(r)));
    end
    for (int r = 0; r < 6; r++) wr(A_LVL + 8'(r), 8'hff);
    for (int i = 0; i < 3; i++) rdchk("mask_rst", A_MSK + 8'(i), 8'h00);
    rd_stat(st);
    chk("stat_rst", st, 24'h000000);
    // Unmapped places read zero; strobes with the enable low are lost
    rdchk("unmapped", 8'h7f, 8'h00);
    rdchk("unmapped", 8'h86, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    wr(A_LVL, 8'h00);
    ce <= 1'b1;
    rdchk("ce_low", A_LVL, 8'hff);
    // Masks open: each source alone reaches its own request and vector
    wr3(A_MSK, 8'hff);
    for (int s = 0; s < 16; s++) begin
      pulse(16'h0001 << s);
      rd_stat(st);
      chk("route", st, 24'h000001 << req_of[s]);
      chk("irq_set", 24'(irq), 24'h1);
      chk("cpu_num", 24'(t_num), 24'(req_of[s]));
      chk("cpu_up", 24'(t_up), 24'(16'hfffa - 16'(2 * req_of[s])));
      chk("cpu_lo", 24'(t_lo), 24'(16'hfffb - 16'(2 * req_of[s])));
      wr3(A_ST, 8'hff);
    end
    // All sources together: equal levels served from request 0 upward
    pulse(16'hffff);
    rd_stat(st);
    exp_st = 24'h000000;
    for (int s = 0; s < 16; s++) exp_st[req_of[s]] = 1'b1;
    chk("all_pending", st, exp_st);
    for (int n = 0; n < 24; n++) begin
      if (exp_st[n]) begin
        chk("winner", 24'(t_num), 24'(n));
        wr(A_ST + 8'(n / 8), 8'h01 << (n % 8));
        wait2();
      end
    end
    chk("irq_clear", 24'(irq), 24'h0);
    chk("valid_clear", 24'(vld), 24'h0);
    // A better level beats the fixed order: request 23 at level 0
    wr(A_LVL + 8'h05, 8'h3f);
    pulse(16'h8004);
    chk("lvl_win", 24'(t_num), 24'd23);
    chk("lvl_out", 24'(lvl), 24'h0);
    // Closed masks hide pending bits from the core but keep them
    wr3(A_MSK, 8'h00);
    wait2();
    chk("irq_masked", 24'(irq), 24'h0);
    chk("valid_masked", 24'(vld), 24'h0);
    d = t_cnt;
    wait2();
    chk("no_fetch", 24'(t_cnt), 24'(d));
    rd_stat(st);
    chk("masked_pending", st, 24'h800001);
    // A source still high beats a clear of its bit in the same cycle
    @(posedge clk);
    src <= 16'h0040;
    wr(A_ST, 8'h21);
    src <= 16'h0000;
    rd(A_ST, d);
    chk("set_wins", 24'(d), 24'h20);
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> dv/irm_cpu_model.sv
// CPU-side model: fetches the vector of the winning request
`default_nettype none
module irm_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [4:0] req_num,
  input wire logic [15:0] vec_upper,
  input wire logic [15:0] vec_lower,
  output logic [4:0] took_num,
  output logic [15:0] took_upper,
  output logic [15:0] took_lower,
  output logic [7:0] took_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // The core fetches only while a request is flagged valid; the last
  // fetch is kept so the bench can tell a missing fetch from a stale one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      took_num <= 5'h1f;
      took_upper <= 16'h0000;
      took_lower <= 16'h0000;
      took_cnt <= 8'h00;
    end else if (req_valid) begin
      took_num <= req_num;
      took_upper <= vec_upper;
      took_lower <= vec_lower;
      took_cnt <= took_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> hw/irm_arb.sv
// Fixed-order arbiter: best level first, then lowest request number
`default_nettype none
module irm_arb (
  irm_arb_if.arb bus
);
  logic hit;
  logic [4:0] num;
  logic [1:0] best;
  logic beaten;

  // Walk from the last request down so a lower number wins a tie
  always_comb begin
    hit = 1'b0;
    num = '0;
    best = irm_pkg::LVL_LOWEST;
    for (int i = irm_pkg::NUM_REQ - 1; i >= 0; i--) begin
      if (bus.pend[i] &&
          irm_pkg::lvl_of(bus.lvl, 5'(i)) <= best) begin
        hit = 1'b1;
        num = 5'(i);
        best = irm_pkg::lvl_of(bus.lvl, 5'(i));
      end
    end
  end

  assign bus.hit = hit;
  assign bus.num = num;
  assign bus.lvl_sel = best;

  // Checker helper: some pending request should have won instead
  always_comb begin
    beaten = 1'b0;
    for (int j = 0; j < irm_pkg::NUM_REQ; j++) begin
      if (bus.pend[j] &&
          (irm_pkg::lvl_of(bus.lvl, 5'(j)) < best ||
           (irm_pkg::lvl_of(bus.lvl, 5'(j)) == best && 5'(j) < num)))
        beaten = 1'b1;
    end
  end

  property p_arb_order;
    @(posedge bus.clk) disable iff (!bus.rst_n)
      hit |-> !beaten && bus.pend[num];
  endproperty
  a_arb_order: assert property (p_arb_order)
    else $error("arbiter picked a request that loses the fixed order");
endmodule
`default_nettype wire

// >>> hw/irm_top.sv
// Interrupt request mapper: source routing, levels, status and vectors
//
// Contract
// - 24 requests, numbers 0 to 23, each with a 2-bit level field.
// - Request n vector: upper at top minus 2n, lower one above.
// - Equal levels pending together: lowest request number served first.
// - External channel 4 drives request 0, channel 5 drives request 1.
// - Channels 2 or 6 drive request 2; channels 3 or 7 request 3.
// - Timer 0 lower half raises request 5, upper half request 6.
// - Timer 1 upper half raises request 14, lower half request 22.
// - Level fields live in byte registers, read/write, reset all ones.
`default_nettype none
module irm_top (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [5:0] EXT_REQ,
  input wire logic TMR0_LO,
  input wire logic TMR0_HI,
  input wire logic TMR1_LO,
  input wire logic TMR1_HI,
  input wire logic UART_RX,
  input wire logic UART_TX,
  input wire logic ADC_DONE,
  input wire logic TBT_TICK,
  input wire logic WPRE_TICK,
  input wire logic FLASH_DONE,
  output logic IRQ,
  output logic REQ_VALID,
  output logic [4:0] REQ_NUM,
  output logic [1:0] REQ_LEVEL,
  output logic [15:0] VEC_UPPER,
  output logic [15:0] VEC_LOWER
);
  localparam int NR = irm_pkg::NUM_REQ;
  localparam int NB = irm_pkg::NUM_BYTE_REG;
  localparam int NL = irm_pkg::NUM_LVL_REG;

  logic rst_meta_r;
  logic rst_n;
  logic [23:0] src;
  logic [23:0] stat_r;
  logic [23:0] stat_nxt;
  logic [23:0] wclr;
  logic [23:0] mask_flat;
  logic [47:0] lvl_flat;
  logic [7:0] lvl_r [NL];
  logic [7:0] mask_r [NB];
  logic [NL-1:0] lvl_wr;
  logic [NL-1:0] lvl_rd;
  logic [NB-1:0] stat_wr;
  logic [NB-1:0] stat_rd;
  logic [NB-1:0] mask_wr;
  logic [NB-1:0] mask_rd;
  logic [7:0] rd_nxt;
  logic [4:0] num_nxt;
  logic [15:0] vup_nxt;

  // Address hit of one byte register in a group
  function automatic logic hit_at(input logic [7:0] addr,
                                  input logic [7:0] base,
                                  input int idx);
    return addr == base + 8'(idx);
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Source routing; unused numbers are tied off by the assigned mask
  always_comb begin
    src = '0;
    src[irm_pkg::REQ_EXT4] = EXT_REQ[irm_pkg::EXT_CH4];
    src[irm_pkg::REQ_EXT5] = EXT_REQ[irm_pkg::EXT_CH5];
    src[irm_pkg::REQ_EXT26] = EXT_REQ[irm_pkg::EXT_CH2] |
                              EXT_REQ[irm_pkg::EXT_CH6];
    src[irm_pkg::REQ_EXT37] = EXT_REQ[irm_pkg::EXT_CH3] |
                              EXT_REQ[irm_pkg::EXT_CH7];
    src[irm_pkg::REQ_TMR0_LO] = TMR0_LO;
    src[irm_pkg::REQ_TMR0_HI] = TMR0_HI;
    src[irm_pkg::REQ_UART_RX] = UART_RX;
    src[irm_pkg::REQ_UART_TX] = UART_TX;
    src[irm_pkg::REQ_TMR1_HI] = TMR1_HI;
    src[irm_pkg::REQ_ADC] = ADC_DONE;
    src[irm_pkg::REQ_TBT] = TBT_TICK;
    src[irm_pkg::REQ_WPRE] = WPRE_TICK;
    src[irm_pkg::REQ_TMR1_LO] = TMR1_LO;
    src[irm_pkg::REQ_FLASH] = FLASH_DONE;
  end

  // Register decode, one hit line per byte register
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lvl_dec
      assign lvl_wr[g] = REG_WR && hit_at(REG_ADDR, irm_pkg::ADDR_LVL0, g);
      assign lvl_rd[g] = hit_at(REG_ADDR, irm_pkg::ADDR_LVL0, g);
    end
    for (g = 0; g < NB; g++) begin : g_byte_dec
      assign stat_wr[g] =
        REG_WR && hit_at(REG_ADDR, irm_pkg::ADDR_STAT0, g);
      assign stat_rd[g] = hit_at(REG_ADDR, irm_pkg::ADDR_STAT0, g);
      assign mask_wr[g] =
        REG_WR && hit_at(REG_ADDR, irm_pkg::ADDR_MASK0, g);
      assign mask_rd[g] = hit_at(REG_ADDR, irm_pkg::ADDR_MASK0, g);
      assign mask_flat[g*8 +: 8] = mask_r[g];
    end
  endgenerate

  // Level registers: four 2-bit fields per byte, request 4r+k at bits 2k
  generate
    for (g = 0; g < NL; g++) begin : g_lvl
      always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          lvl_r[g] <= irm_pkg::LVL_RST;
        end else if (CE && lvl_wr[g]) begin
          lvl_r[g] <= REG_WDATA;
        end
      end
      assign lvl_flat[g*8 +: 8] = lvl_r[g];
    end
  endgenerate

  // Mask registers; every source starts masked off from the IRQ line
  generate
    for (g = 0; g < NB; g++) begin : g_mask
      always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          mask_r[g] <= irm_pkg::MASK_RST;
        end else if (CE && mask_wr[g]) begin
          mask_r[g] <= REG_WDATA;
        end
      end
    end
  endgenerate

  // Sticky status: a source held high keeps re-setting its bit, so the
  // set beats a write-one-to-clear landing in the same cycle
  generate
    for (g = 0; g < NR; g++) begin : g_stat
      assign wclr[g] = stat_wr[g / 8] && REG_WDATA[g % 8];
      assign stat_nxt[g] = irm_pkg::ASSIGNED[g] &&
                           (src[g] || (stat_r[g] && !wclr[g]));
    end
  endgenerate

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else if (CE) begin
      stat_r <= stat_nxt;
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rd_nxt = irm_pkg::RD_IDLE;
    for (int i = 0; i < NL; i++) begin
      if (lvl_rd[i])
        rd_nxt = lvl_r[i];
    end
    for (int i = 0; i < NB; i++) begin
      if (stat_rd[i])
        rd_nxt = stat_r[i*8 +: 8];
      if (mask_rd[i])
        rd_nxt = mask_r[i];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= irm_pkg::RD_IDLE;
    end else if (CE) begin
      REG_RDATA <= REG_RD ? rd_nxt : irm_pkg::RD_IDLE;
    end
  end

  // Level output interrupt from unmasked sticky bits
  assign IRQ = |(stat_r & mask_flat);

  // Arbitration among unmasked pending requests
  irm_arb_if arb_bus (
    .clk(CLK_SYS),
    .rst_n(rst_n)
  );
  assign arb_bus.pend = stat_r & mask_flat;
  assign arb_bus.lvl = lvl_flat;

  irm_arb u_arb (
    .bus(arb_bus)
  );

  assign num_nxt = arb_bus.hit ? arb_bus.num : 5'h00;
  assign vup_nxt = irm_pkg::vec_upper(num_nxt);

  // Winner registered towards the core; vectors follow one cycle later
  // than the status, a cost paid for flop-driven data outputs
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      REQ_VALID <= 1'b0;
      REQ_NUM <= 5'h00;
      REQ_LEVEL <= irm_pkg::LVL_LOWEST;
      VEC_UPPER <= irm_pkg::VEC_TOP;
      VEC_LOWER <= irm_pkg::VEC_TOP + irm_pkg::VEC_LOW_OFS;
    end else if (CE) begin
      REQ_VALID <= arb_bus.hit;
      REQ_NUM <= num_nxt;
      REQ_LEVEL <= arb_bus.hit ? arb_bus.lvl_sel : irm_pkg::LVL_LOWEST;
      VEC_UPPER <= vup_nxt;
      VEC_LOWER <= vup_nxt + irm_pkg::VEC_LOW_OFS;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  property p_level_sel;
    CE && REQ_VALID && $stable(lvl_flat) |->
      REQ_LEVEL == irm_pkg::lvl_of(lvl_flat, REQ_NUM);
  endproperty
  a_level_sel: assert property (p_level_sel)
    else $error("reported level differs from the request's field");

  property p_vector;
    REQ_VALID |-> VEC_UPPER == irm_pkg::VEC_TOP - {10'h000, REQ_NUM, 1'b0}
      && VEC_LOWER == VEC_UPPER + irm_pkg::VEC_LOW_OFS;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector address does not match the request number");

  property p_first_wins;
    CE && stat_r[0] && mask_flat[0] &&
      irm_pkg::lvl_of(lvl_flat, 5'h00) == irm_pkg::LVL_LOWEST |=>
      REQ_VALID && (REQ_NUM == 5'h00 || REQ_LEVEL != irm_pkg::LVL_LOWEST);
  endproperty
  a_first_wins: assert property (p_first_wins)
    else $error("request 0 lost a tie at its level");

  property p_ext_own;
    CE && EXT_REQ[irm_pkg::EXT_CH4] && EXT_REQ[irm_pkg::EXT_CH5] |=>
      stat_r[irm_pkg::REQ_EXT4] && stat_r[irm_pkg::REQ_EXT5];
  endproperty
  a_ext_own: assert property (p_ext_own)
    else $error("channel 4 or 5 did not reach its request");

  property p_ext_shared;
    CE && (EXT_REQ[irm_pkg::EXT_CH2] || EXT_REQ[irm_pkg::EXT_CH6]) |=>
      stat_r[irm_pkg::REQ_EXT26];
  endproperty
  a_ext_shared: assert property (p_ext_shared)
    else $error("channel 2 or 6 did not set request 2");

  property p_ext_shared3;
    CE && $past(CE) && !stat_r[irm_pkg::REQ_EXT37] |->
      !$past(EXT_REQ[irm_pkg::EXT_CH3] || EXT_REQ[irm_pkg::EXT_CH7]);
  endproperty
  a_ext_shared3: assert property (p_ext_shared3)
    else $error("channel 3 or 7 request was lost");

  property p_tmr0;
    CE ##0 (TMR0_LO || TMR0_HI) |=>
      (stat_r[irm_pkg::REQ_TMR0_LO] || !$past(TMR0_LO)) &&
      (stat_r[irm_pkg::REQ_TMR0_HI] || !$past(TMR0_HI));
  endproperty
  a_tmr0: assert property (p_tmr0)
    else $error("timer 0 half did not set its request");

  property p_tmr1;
    CE && TMR1_HI && TMR1_LO |=>
      stat_r[irm_pkg::REQ_TMR1_HI] && stat_r[irm_pkg::REQ_TMR1_LO];
  endproperty
  a_tmr1: assert property (p_tmr1)
    else $error("timer 1 half did not set its request");

  property p_lvl_reset;
    $rose(rst_n) |-> lvl_flat == '1 ##1 lvl_flat == '1 || $past(REG_WR);
  endproperty
  a_lvl_reset: assert property (p_lvl_reset)
    else $error("level registers not all ones after reset");

  property p_lvl_rw;
    CE && lvl_wr[0] ##1 CE && REG_RD && lvl_rd[0] && !REG_WR |=>
      REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  a_lvl_rw: assert property (p_lvl_rw)
    else $error("level register did not read back its written value");

  property p_unused_quiet;
    (stat_r & ~irm_pkg::ASSIGNED) == 24'h000000 &&
      (!REQ_VALID || irm_pkg::ASSIGNED[REQ_NUM]);
  endproperty
  a_unused_quiet: assert property (p_unused_quiet)
    else $error("request without a source became active");

  // A source high at an edge wins over a clear landing at the same edge
  property p_src_sets;
    CE && rst_n |=> (stat_r & $past(src & irm_pkg::ASSIGNED)) ==
      $past(src & irm_pkg::ASSIGNED);
  endproperty
  a_src_sets: assert property (p_src_sets)
    else $error("a source event did not set its status bit");

  // With the enable low no flop but the reset synchronizer moves, so software sees a frozen block
  property p_ce_freeze;
    !CE |=> $stable(stat_r) && $stable(lvl_flat) && $stable(REG_RDATA) &&
      $stable(REQ_NUM);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while the clock enable was low");

  // Read data are zero except in the cycle after a read strobe
  property p_rd_idle;
    CE && !REG_RD |=> REG_RDATA == irm_pkg::RD_IDLE;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data stood outside their one cycle");

  // The core sees a request exactly one edge after the interrupt line
  property p_valid_follows;
    CE |=> REQ_VALID == $past(IRQ);
  endproperty
  a_valid_follows: assert property (p_valid_follows)
    else $error("request valid does not follow the interrupt line");

  c_tie: cover property (CE && stat_r[0] && stat_r[1] &&
                         mask_flat[1:0] == 2'h3);
  c_lvl_write: cover property (CE && lvl_wr[5]);
  c_irq: cover property (IRQ ##1 !IRQ);
  c_last: cover property (REQ_VALID && REQ_NUM == 5'h17);
endmodule
`default_nettype wire

// >>> include/irm_arb_if.sv
// Interface: pending requests and levels into the arbiter, winner out
`default_nettype none
interface irm_arb_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [23:0] pend;
  logic [47:0] lvl;
  logic hit;
  logic [4:0] num;
  logic [1:0] lvl_sel;
  modport arb (input clk, rst_n, pend, lvl, output hit, num, lvl_sel);
  modport top (input hit, num, lvl_sel, output pend, lvl);
endinterface
`default_nettype wire

// >>> include/irm_pkg.sv
// Package: shared constants and decoders of the interrupt request mapper
`default_nettype none
package irm_pkg;
  localparam int NUM_REQ = 24;
  localparam int LVL_W = 2;
  localparam int REQ_W = 5;
  localparam int BYTE_W = 8;
  localparam int NUM_LVL_REG = 6;
  localparam int NUM_BYTE_REG = 3;
  localparam int FLD_PER_REG = 4;
  localparam int NUM_EXT = 6;
  localparam int LVL_FLAT_W = NUM_REQ * LVL_W;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_LVL0 = 8'h79;
  localparam logic [7:0] ADDR_STAT0 = 8'h80;
  localparam logic [7:0] ADDR_MASK0 = 8'h83;
  // Reset and idle values
  localparam logic [7:0] LVL_RST = 8'hff;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] RD_IDLE = 8'h00;
  localparam logic [1:0] LVL_LOWEST = 2'h3;
  // Vector entry of request 0; later requests sit two bytes lower
  localparam logic [15:0] VEC_TOP = 16'hfffa;
  localparam logic [15:0] VEC_LOW_OFS = 16'h0001;
  // Requests that own a source; all others stay inactive
  localparam logic [23:0] ASSIGNED = 24'hdc41ef;
  // Request number of each source
  localparam int REQ_EXT4 = 0;
  localparam int REQ_EXT5 = 1;
  localparam int REQ_EXT26 = 2;
  localparam int REQ_EXT37 = 3;
  localparam int REQ_TMR0_LO = 5;
  localparam int REQ_TMR0_HI = 6;
  localparam int REQ_UART_RX = 7;
  localparam int REQ_UART_TX = 8;
  localparam int REQ_TMR1_HI = 14;
  localparam int REQ_ADC = 18;
  localparam int REQ_TBT = 19;
  localparam int REQ_WPRE = 20;
  localparam int REQ_TMR1_LO = 22;
  localparam int REQ_FLASH = 23;
  // Position of external channel n in the external vector is n minus two
  localparam int EXT_CH2 = 0;
  localparam int EXT_CH3 = 1;
  localparam int EXT_CH4 = 2;
  localparam int EXT_CH5 = 3;
  localparam int EXT_CH6 = 4;
  localparam int EXT_CH7 = 5;

  // Level field of one request out of the flat level vector
  function automatic logic [1:0] lvl_of(input logic [47:0] f,
                                        input logic [4:0] n);
    return f[{n, 1'b0} +: LVL_W];
  endfunction

  // Upper byte address of the vector entry of a request
  function automatic logic [15:0] vec_upper(input logic [4:0] n);
    return VEC_TOP - {10'h000, n, 1'b0};
  endfunction
endpackage
`default_nettype wire
